// ### inc/laser_safety_regs.svh
// register offsets, field positions, reset values and time counts
// assumes a 25 MHz ref_clk and a 0.5 ms internal time base
`ifndef LASER_SAFETY_REGS_SVH
`define LASER_SAFETY_REGS_SVH
// clock and time base
`define LSF_CLK_MHZ 25
`define LSF_TICK_US 500
`define LSF_TICK_CYC (`LSF_TICK_US * `LSF_CLK_MHZ)
// documented times, in microseconds
`define LSF_INIT_US 50000
`define LSF_START_US 300000
`define LSF_CONV_US 100000
`define LSF_GLITCH_US 10000
// times in ticks, least times rounded up
`define LSF_INIT_TICKS ((`LSF_INIT_US + `LSF_TICK_US - 1) / `LSF_TICK_US)
`define LSF_START_TICKS ((`LSF_START_US + `LSF_TICK_US - 1) / `LSF_TICK_US)
`define LSF_CONV_TICKS ((`LSF_CONV_US + `LSF_TICK_US - 1) / `LSF_TICK_US)
`define LSF_GLITCH_TICKS ((`LSF_GLITCH_US + `LSF_TICK_US - 1) / `LSF_TICK_US)
// byte offsets on the register bus
`define LSF_OFS_CFG 5'h00
`define LSF_OFS_MASK 5'h04
`define LSF_OFS_MODNOM 5'h08
`define LSF_OFS_MODDIR 5'h0C
`define LSF_OFS_BLANK 5'h10
`define LSF_OFS_LOS 5'h14
`define LSF_OFS_STAT 5'h18
// reset values
`define LSF_CFG_RST 10'h000
`define LSF_MASK_RST 5'h00
`define LSF_BLANK_RST 8'h01
`define LSF_LOS_RST 16'h0000
// fault source bit positions
`define LSF_FLT_SUPPLY 0
`define LSF_FLT_DIODE 1
`define LSF_FLT_BIAS 2
`define LSF_FLT_TXPWR 3
`define LSF_FLT_SAT 4
`endif

// ### inc/laser_safety_pkg.sv
// types shared by the laser safety and fault control block
// assumes the constants header is included by the design
package laser_safety_pkg;
    // control bits, bit 0 at the bottom
    typedef struct packed {
        logic soft_tx_off;
        logic los_compare_off;
        logic ext_fault_polarity;
        logic ext_fault_mode;
        logic feedback_invert;
        logic cutoff_polarity;
        logic bias_drive_polarity;
        logic mod_dac_polarity;
        logic power_loop_off;
        logic oe;
    } cfg_t;
    // laser sequence states, one-hot
    typedef enum logic [3:0] {
        st_init = 4'b0001,
        st_wait = 4'b0010,
        st_off = 4'b0100,
        st_run = 4'b1000
    } laser_state_t;
endpackage

// ### logic/laser_safety_fault_control.sv
// laser start-up, modulation source, shutdown outputs and fault logic
// assumes an avalon-mm master on ref_clk and analog parts outside
`timescale 1ns/1ps
`include "laser_safety_regs.svh"
module laser_safety_fault_control
    import laser_safety_pkg::*;
#(
    parameter int TICK_CYC = `LSF_TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic tx_disable_pin,
    input wire logic [4:0] fault_cmp_raw,
    input wire logic [7:0] rx_power_in,
    input wire logic [7:0] mod_comp_table,
    input wire logic rxlos_in,
    input wire logic cutoff_in,
    output logic [7:0] mod_dac_out,
    output logic mod_dac_oe_n,
    output logic bias_drive_out,
    output logic bias_loop_run,
    output logic bias_drive_oe_n,
    output logic laser_cutoff_out,
    output logic cutoff_oe_n,
    output logic tx_fault_out,
    output logic tx_fault_oe_n,
    output logic rxlos_out,
    output logic rxlos_oe_n,
    output logic data_ready
);
    localparam int GLT = `LSF_GLITCH_TICKS;

    cfg_t cfg; // control bits
    logic [4:0] fault_mask_reg; // 1 disables a source
    logic [7:0] mod_nominal_value; // nominal modulation
    logic [7:0] mod_direct; // direct modulation code
    logic [7:0] saturation_blank_time; // in 0.5 ms steps
    logic [7:0] los_assert_level; // rxlos set below this
    logic [7:0] los_release_level; // rxlos clear above this
    logic [7:0] sync1; // first synchroniser stage
    logic [7:0] sync2; // second synchroniser stage
    logic txd; // synced tx disable
    logic txd_prev; // tx disable one cycle ago
    logic txd_fall; // tx disable released
    logic [13:0] pre_cnt; // time base prescaler
    logic tick; // one 0.5 ms pulse
    logic [9:0] pwr_cnt; // ticks since reset
    logic init_done; // init period over
    laser_state_t state; // laser sequence
    laser_state_t next_state;
    logic shut_req; // laser must be off
    logic [4:0] flt_qual; // persisting faults
    logic [4:0] fault_set; // unmasked qualified faults
    logic [4:0] fault_latched; // sticky fault bits
    logic [7:0] blank_cnt; // saturation blanking left
    logic run_prev; // laser on one cycle ago
    logic ext_fault; // external fault active
    logic tx_fault; // combined fault
    logic los_state; // comparator rxlos
    logic [7:0] next_mod; // modulation before polarity
    logic [9:0] comp_sum; // nominal plus table
    logic ack; // bus answer cycle
    logic [31:0] cfg_merged; // cfg with write lanes applied
    logic [31:0] los_merged; // los levels with write lanes applied

    // merge write data into a register by byte lanes
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // lane merge of the wide registers, sliced at the write
    assign cfg_merged = merge(32'(cfg), writedata, byteenable);
    assign los_merged = merge({16'h0000, los_release_level,
        los_assert_level}, writedata, byteenable);

    // two-flop synchronisers for pins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else begin
            sync1 <= {cutoff_in, rxlos_in, tx_disable_pin,
                fault_cmp_raw};
            sync2 <= sync1;
        end
    end
    assign txd = sync2[5];
    assign txd_fall = txd_prev & ~txd;

    // tx disable edge history
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            txd_prev <= 1'b0;
        end else begin
            txd_prev <= txd;
        end
    end

    // 0.5 ms time base
    always_ff @(posedge ref_clk) begin
        if (sys_rst || tick) begin
            pre_cnt <= 14'h0000;
        end else begin
            pre_cnt <= pre_cnt + 14'h0001;
        end
    end
    assign tick = (pre_cnt == 14'(TICK_CYC - 1));

    // power-on tick counter, saturating
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pwr_cnt <= 10'h000;
        end else if (tick && pwr_cnt != 10'h3FF) begin
            pwr_cnt <= pwr_cnt + 10'h001;
        end
    end
    assign init_done = (pwr_cnt >= 10'(`LSF_INIT_TICKS));

    // data ready one conversion after init
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            data_ready <= 1'b0;
        end else begin
            data_ready <= (pwr_cnt >=
                10'(`LSF_INIT_TICKS + `LSF_CONV_TICKS));
        end
    end

    // glitch filter per fault source
    for (genvar i = 0; i < 5; i++) begin : g_flt
        logic [5:0] gcnt; // ticks the source has held
        always_ff @(posedge ref_clk) begin
            if (sys_rst || !sync2[i]) begin
                gcnt <= 6'h00;
            end else if (tick && gcnt != 6'(GLT)) begin
                gcnt <= gcnt + 6'h01;
            end
        end
        assign flt_qual[i] = (gcnt == 6'(GLT));
    end

    // saturation blanking after laser turn-on
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            blank_cnt <= 8'h00;
        end else if (state == st_run && !run_prev) begin
            blank_cnt <= saturation_blank_time;
        end else if (tick && blank_cnt != 8'h00) begin
            blank_cnt <= blank_cnt - 8'h01;
        end
    end

    // mask the qualified faults and blank the saturation fault
    always_comb begin
        fault_set = flt_qual & ~fault_mask_reg;
        if (blank_cnt != 8'h00) begin
            fault_set[`LSF_FLT_SAT] = 1'b0;
        end
    end

    // sticky faults, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fault_latched <= 5'h00;
        end else begin
            fault_latched <= (fault_latched & ~{5{txd_fall}})
                | fault_set;
        end
    end

    // external fault input and combined fault
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ext_fault <= 1'b0;
            tx_fault <= 1'b0;
        end else begin
            ext_fault <= cfg.ext_fault_mode
                && (sync2[7] == cfg.ext_fault_polarity);
            tx_fault <= (|fault_latched) | ext_fault;
        end
    end

    // reasons for holding the laser off
    assign shut_req = txd | cfg.soft_tx_off | tx_fault | ~cfg.oe;

    // laser sequence next state
    always_comb begin
        next_state = state;
        case (state)
            st_init: begin
                if (init_done) begin
                    next_state = st_wait;
                end
            end
            st_wait: begin
                if (pwr_cnt >= 10'(`LSF_START_TICKS)) begin
                    next_state = shut_req ? st_off : st_run;
                end
            end
            st_off: begin
                if (!shut_req) begin
                    next_state = st_run;
                end
            end
            st_run: begin
                if (shut_req) begin
                    next_state = st_off;
                end
            end
            default: begin
                next_state = st_init;
            end
        endcase
    end

    // laser sequence state register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= st_init;
            run_prev <= 1'b0;
        end else begin
            state <= next_state;
            run_prev <= (state == st_run);
        end
    end

    // modulation source select with clamp
    always_comb begin
        comp_sum = {2'b00, mod_nominal_value}
            + {{2{mod_comp_table[7]}}, mod_comp_table};
        if (state != st_run) begin
            next_mod = 8'h00;
        end else if (cfg.power_loop_off) begin
            next_mod = mod_direct;
        end else if (comp_sum[9]) begin
            next_mod = 8'h00;
        end else if (comp_sum[8]) begin
            next_mod = 8'hFF;
        end else begin
            next_mod = comp_sum[7:0];
        end
    end

    // laser control outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mod_dac_out <= 8'h00;
            mod_dac_oe_n <= 1'b1;
            bias_drive_out <= 1'b0;
            bias_loop_run <= 1'b0;
            bias_drive_oe_n <= 1'b1;
            laser_cutoff_out <= 1'b0;
            cutoff_oe_n <= 1'b1;
        end else begin
            mod_dac_out <= next_mod ^ {8{cfg.mod_dac_polarity}};
            mod_dac_oe_n <= ~cfg.oe;
            bias_drive_out <= cfg.bias_drive_polarity;
            bias_loop_run <= (state == st_run);
            bias_drive_oe_n <= ~cfg.oe;
            // active level is the polarity bit
            laser_cutoff_out <= (state == st_run)
                ? ~cfg.cutoff_polarity : cfg.cutoff_polarity;
            cutoff_oe_n <= ~cfg.oe | cfg.ext_fault_mode;
        end
    end

    // open-drain fault pin, rxlos pin driven both ways
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tx_fault_out <= 1'b0;
            tx_fault_oe_n <= 1'b0;
            rxlos_out <= 1'b0;
            rxlos_oe_n <= 1'b1;
        end else begin
            tx_fault_out <= 1'b0;
            tx_fault_oe_n <= tx_fault;
            rxlos_out <= los_state;
            rxlos_oe_n <= cfg.los_compare_off;
        end
    end

    // rxlos comparator with hysteresis
    always_ff @(posedge ref_clk) begin
        if (sys_rst || cfg.los_compare_off) begin
            los_state <= 1'b0;
        end else if (rx_power_in < los_assert_level) begin
            los_state <= 1'b1;
        end else if (rx_power_in > los_release_level) begin
            los_state <= 1'b0;
        end
    end

    // bus handshake, one wait cycle, held off during init
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & init_done & ~ack;
            waitrequest <= ~((read | write) & init_done & ~ack);
        end
    end

    // register writes at the accepting edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg <= `LSF_CFG_RST;
            fault_mask_reg <= `LSF_MASK_RST;
            mod_nominal_value <= 8'h00;
            mod_direct <= 8'h00;
            saturation_blank_time <= `LSF_BLANK_RST;
            {los_release_level, los_assert_level} <= `LSF_LOS_RST;
        end else if (write && !waitrequest) begin
            case (address)
                `LSF_OFS_CFG: begin
                    cfg <= cfg_merged[9:0];
                end
                `LSF_OFS_MASK: begin
                    if (byteenable[0]) begin
                        fault_mask_reg <= writedata[4:0];
                    end
                end
                `LSF_OFS_MODNOM: begin
                    if (byteenable[0]) begin
                        mod_nominal_value <= writedata[7:0];
                    end
                end
                `LSF_OFS_MODDIR: begin
                    if (byteenable[0]) begin
                        mod_direct <= writedata[7:0];
                    end
                end
                `LSF_OFS_BLANK: begin
                    if (byteenable[0]) begin
                        saturation_blank_time <= writedata[7:0];
                    end
                end
                `LSF_OFS_LOS: begin
                    {los_release_level, los_assert_level} <=
                        los_merged[15:0];
                end
                default: begin
                    // unmapped and read-only offsets ignore writes
                end
            endcase
        end
    end

    // read data, ready in the answer cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            readdata <= 32'h0000_0000;
        end else if (read) begin
            case (address)
                `LSF_OFS_CFG: readdata <= {22'h000000, cfg};
                `LSF_OFS_MASK: readdata <= {27'h0, fault_mask_reg};
                `LSF_OFS_MODNOM: readdata <= {24'h0, mod_nominal_value};
                `LSF_OFS_MODDIR: readdata <= {24'h0, mod_direct};
                `LSF_OFS_BLANK:
                    readdata <= {24'h0, saturation_blank_time};
                `LSF_OFS_LOS: readdata <= {16'h0000,
                    los_release_level, los_assert_level};
                // status
                `LSF_OFS_STAT: readdata <= {19'h0, init_done,
                    data_ready, state == st_run, sync2[6],
                    tx_fault, ext_fault, 2'b00, fault_latched};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // fault latches, then txfault, then the laser leaves run
    sequence s_fault_shut;
        ##2 tx_fault ##1 (state != st_run);
    endsequence

    property p_fault_shut;
        (|fault_set) && !txd_fall |-> s_fault_shut;
    endproperty
    a_fault_shut: assert property (p_fault_shut)
        else $error("fault did not shut the laser");

    property p_mod_shut;
        state != st_run
            |=> mod_dac_out == {8{$past(cfg.mod_dac_polarity)}};
    endproperty
    a_mod_shut: assert property (p_mod_shut)
        else $error("modulation shutdown level wrong");

    property p_mod_direct;
        state == st_run && cfg.power_loop_off |=> mod_dac_out ==
            ($past(mod_direct) ^ {8{$past(cfg.mod_dac_polarity)}});
    endproperty
    a_mod_direct: assert property (p_mod_direct)
        else $error("direct modulation not loaded");

    property p_float;
        !cfg.oe |=> mod_dac_oe_n && bias_drive_oe_n && cutoff_oe_n;
    endproperty
    a_float: assert property (p_float)
        else $error("outputs driven with enable clear");

    property p_latch;
        !txd_fall |=> (fault_latched & $past(fault_latched))
            == $past(fault_latched);
    endproperty
    a_latch: assert property (p_latch)
        else $error("latched fault lost without toggle");

    property p_blank;
        blank_cnt != 8'h00 && !fault_latched[`LSF_FLT_SAT]
            |=> !fault_latched[`LSF_FLT_SAT];
    endproperty
    a_blank: assert property (p_blank)
        else $error("saturation fault during blanking");

    property p_glitch;
        !sync2[0] |=> !flt_qual[0];
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("fault qualified without persisting");

    property p_los_set;
        !cfg.los_compare_off && rx_power_in < los_assert_level
            |=> los_state ##1 rxlos_out;
    endproperty
    a_los_set: assert property (p_los_set)
        else $error("rxlos not asserted below level");

    property p_init_wait;
        !init_done |=> waitrequest && state != st_run;
    endproperty
    a_init_wait: assert property (p_init_wait)
        else $error("access or laser before init");

    property p_txfault_pin;
        tx_fault |=> tx_fault_oe_n && !tx_fault_out;
    endproperty
    a_txfault_pin: assert property (p_txfault_pin)
        else $error("txfault pin not released");

    property p_cutoff;
        state != st_run && !cfg.ext_fault_mode && cfg.oe
            |=> !cutoff_oe_n
            && laser_cutoff_out == $past(cfg.cutoff_polarity);
    endproperty
    a_cutoff: assert property (p_cutoff)
        else $error("cutoff not active in shutdown");

endmodule

// ### verification/laser_far_side.sv
// far side: shared cutoff pin, rxlos wire, open-drain txfault wire
// assumes the bench steers ext_en, ext_lvl and ext_los
`timescale 1ns/1ps
module laser_far_side (
    input wire logic ref_clk,
    input wire logic laser_cutoff_out,
    input wire logic cutoff_oe_n,
    input wire logic tx_fault_out,
    input wire logic tx_fault_oe_n,
    input wire logic rxlos_out,
    input wire logic rxlos_oe_n,
    input wire logic ext_en,
    input wire logic ext_lvl,
    input wire logic ext_los,
    output logic cutoff_in,
    output logic rxlos_in,
    output logic txf_pin
);
    logic last = 1'b0; // last level of the shared pin
    // the cutoff pin, when nobody drives it, shows the inverse of its last driven level
    always @(posedge ref_clk) begin
        if (!cutoff_oe_n || ext_en) begin
            last <= cutoff_in;
        end
    end
    // block drives, else an external fault source may
    assign cutoff_in = !cutoff_oe_n ? laser_cutoff_out
        : ext_en ? ext_lvl : ~last;
    // released rxlos: pull-up or another device
    assign rxlos_in = rxlos_oe_n ? ext_los : rxlos_out;
    // open drain with pull-up
    assign txf_pin = tx_fault_oe_n ? 1'b1 : tx_fault_out;
endmodule

// ### verification/laser_safety_fault_control_tb.sv
// bench: registers, start-up timing, shutdown states, faults, los
// assumes laser_far_side closes the pins
`timescale 1ns/1ps
`include "laser_safety_regs.svh"
module laser_safety_fault_control_tb;
    import laser_safety_pkg::*;
    localparam int TC = 4; // short tick
    localparam int DR = (`LSF_INIT_TICKS + `LSF_CONV_TICKS) * TC;
    localparam int ST = `LSF_START_TICKS * TC;
    localparam int GT = `LSF_GLITCH_TICKS * TC;
    localparam logic [4:0] CFG = `LSF_OFS_CFG;
    localparam logic [4:0] STA = `LSF_OFS_STAT;
    typedef struct packed {
        logic [9:0] cfg;
        logic [7:0] mod;
        logic cut;
    } row_t;
    // config, expected dac code, expected cutoff level
    row_t rows [11] = '{19'h00000, 19'h00200, 19'h03BFF, 19'h04200,
        19'h08200, 19'h00200, 19'h002A1, 19'h00645, 19'h00FBB,
        19'h02644, 19'h002A1};
    logic [4:0] ra [5] = '{CFG, `LSF_OFS_MASK, `LSF_OFS_BLANK,
        `LSF_OFS_LOS, 5'h1C};
    logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
    logic [7:0] lv [3] = '{8'h10, 8'h40, 8'h70}; // rx power steps
    logic ref_clk = 1'b0, sys_rst = 1'b1, read = 1'b0, write = 1'b0;
    logic tx_disable_pin = 1'b0, ext_en = 1'b0, ext_lvl = 1'b0;
    logic ext_los = 1'b1; // host pull-up
    logic [4:0] address = 5'h00, fault_cmp_raw = 5'h00;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [3:0] byteenable = 4'hF;
    logic [7:0] rx_power_in = 8'h80, mod_comp_table = 8'h10;
    logic [7:0] mod_dac_out;
    logic waitrequest, rxlos_in, cutoff_in, mod_dac_oe_n, bias_drive_out;
    logic bias_loop_run, bias_drive_oe_n, laser_cutoff_out, cutoff_oe_n;
    logic tx_fault_out, tx_fault_oe_n, rxlos_out, rxlos_oe_n, data_ready;
    logic txf_pin;
    int errors = 0, check_count = 0, cyc_n = 0, r0 = 0;
    laser_safety_fault_control #(.TICK_CYC(TC))
        laser_safety_fault_control_i (.*);
    laser_far_side laser_far_side_i (.*);
    // clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc_n <= cyc_n + 1;
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // wait until n cycles after reset release
    task automatic at(input int n);
        while (cyc_n - r0 < n) @(posedge ref_clk);
    endtask
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // one avalon cycle, held until waitrequest low
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // fault comparator high for n cycles
    task automatic pulse(input logic [4:0] f, input int n);
        @(posedge ref_clk);
        fault_cmp_raw <= f;
        cyc(n);
        fault_cmp_raw <= 5'h00;
        cyc(10);
    endtask
    task automatic txd(input logic v);
        @(posedge ref_clk);
        tx_disable_pin <= v;
        cyc(10);
    endtask
    // 16-cycle reset, then wait out init with a status read
    task automatic do_reset();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        cyc(3);
        chk("mod_oe_n", 1, mod_dac_oe_n);
        chk("cut_oe_n", 1, cutoff_oe_n);
        chk("bias_oe_n", 1, bias_drive_oe_n);
        chk("txf_pin", 0, txf_pin);
        cyc(13);
        sys_rst <= 1'b0;
        r0 = cyc_n;
        bus(0, STA, 0);
        chk("init", 1, cyc_n - r0 >= `LSF_INIT_TICKS * TC);
        chk("init_done", 1, rd[12]);
    endtask
    // write config, compare pins with the row
    task automatic row(input int i);
        row_t r;
        r = rows[i];
        bus(1, CFG, {22'h0, r.cfg});
        cyc(8);
        chk("mod_oe_n", !r.cfg[0], mod_dac_oe_n);
        chk("cut_oe_n", !r.cfg[0] || r.cfg[6], cutoff_oe_n);
        if (r.cfg[0]) begin
            chk("mod", r.mod, mod_dac_out);
            chk("run", i > 5, bias_loop_run);
        end
        if (r.cfg[0] && !r.cfg[6]) begin
            chk("cut", r.cut, laser_cutoff_out);
        end
        if (r.cfg[0] && i < 6) begin
            chk("bias", r.cfg[3], bias_drive_out);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #800000;
        errors++;
        finish_test();
    end
    // main sequence
    initial begin
        do_reset();
        for (int i = 0; i < 5; i++) begin
            bus(0, ra[i], 0);
            chk("reg_rst", rv[i], rd);
        end
        bus(1, `LSF_OFS_MODNOM, 32'h40);
        bus(1, `LSF_OFS_MODDIR, 32'h22);
        for (int i = 0; i < 6; i++) row(i);
        at(DR - 10);
        chk("ready_early", 0, data_ready);
        at(DR + 15);
        chk("ready", 1, data_ready);
        at(ST - 20);
        chk("early_start", 0, bias_loop_run);
        at(ST + 20);
        chk("start", 1, bias_loop_run);
        for (int i = 6; i < 11; i++) row(i);
        mod_comp_table <= 8'h80; // table pulls the sum below zero
        cyc(4);
        chk("clamp", 0, mod_dac_out);
        mod_comp_table <= 8'h10;
        // masked, glitch, real fault
        bus(1, `LSF_OFS_MASK, 32'h8);
        pulse(5'h08, 2 * GT);
        chk("masked", 0, txf_pin);
        pulse(5'h04, GT * 3 / 4);
        chk("glitch", 0, txf_pin);
        pulse(5'h04, GT * 5 / 4);
        chk("fault", 1, txf_pin);
        chk("shut", 0, bias_loop_run);
        chk("mod_shut", 0, mod_dac_out);
        chk("cut_on", 0, laser_cutoff_out);
        bus(0, STA, 0);
        chk("latched", 32'h4, rd[4:0]);
        txd(1);
        chk("held", 1, txf_pin);
        txd(0);
        chk("cleared", 0, txf_pin);
        chk("restart", 1, bias_loop_run);
        // soft off, then saturation blanking after restart
        bus(1, `LSF_OFS_BLANK, 32'h28);
        bus(1, CFG, 32'h201);
        cyc(8);
        chk("soft_off", 0, bias_loop_run);
        chk("soft_cut", 0, laser_cutoff_out);
        bus(1, CFG, 32'h1);
        pulse(5'h10, 30 * TC);
        chk("blanked", 0, txf_pin);
        pulse(5'h10, 40 * TC);
        chk("sat", 1, txf_pin);
        txd(1);
        txd(0);
        // external fault input, active high
        ext_en <= 1'b1;
        bus(1, CFG, 32'hC1);
        cyc(10);
        chk("ext_idle", 0, txf_pin);
        ext_lvl <= 1'b1;
        cyc(10);
        chk("ext_flt", 1, txf_pin);
        ext_lvl <= 1'b0;
        cyc(10);
        chk("ext_gone", 0, txf_pin);
        bus(1, CFG, 32'h41); // external fault now active low
        cyc(10);
        chk("ext_low", 1, txf_pin);
        // loss of signal hysteresis and pin report
        bus(1, `LSF_OFS_LOS, 32'h6020);
        for (int i = 0; i < 3; i++) begin
            rx_power_in <= lv[i];
            cyc(6);
            chk("rxlos", i < 2, rxlos_out);
        end
        bus(0, STA, 0);
        chk("los_pin", 0, rd[9]);
        rx_power_in <= 8'h10;
        ext_los <= 1'b0;
        bus(1, CFG, 32'h101);
        cyc(6);
        chk("los_oe_n", 1, rxlos_oe_n);
        bus(0, STA, 0);
        chk("los_ext", 0, rd[9]);
        ext_los <= 1'b1;
        cyc(6);
        bus(0, STA, 0);
        chk("los_ext_hi", 1, rd[9]);
        // tx disable held through a second power-up
        tx_disable_pin <= 1'b1;
        do_reset();
        bus(1, CFG, 32'h1);
        at(ST + 50);
        chk("txd_hold", 0, bias_loop_run);
        chk("bias_drv", 0, bias_drive_oe_n);
        chk("bias_lvl", 0, bias_drive_out);
        chk("convert", 1, data_ready);
        finish_test();
    end
endmodule
